// File: pkg/baud_pkg.sv
package baud_pkg;

   // register offsets (byte addresses, one aligned word each)
   localparam logic [4:0] DIV_LO_OFS = 5'h00;
   localparam logic [4:0] DIV_HI_OFS = 5'h04;
   localparam logic [4:0] CTRL_OFS   = 5'h08;
   localparam logic [4:0] COUNT_OFS  = 5'h0c;
   localparam logic [4:0] TICKS_OFS  = 5'h10;

   // control register fields
   localparam int CTRL_WIDE_BIT  = 0;
   localparam int CTRL_HSPEED_BIT = 1;
   localparam int CTRL_SYNC_BIT  = 2;
   localparam int CTRL_W         = 3;

   // reset values
   localparam logic [7:0]        DIV_RST   = 8'h00;
   localparam logic [CTRL_W-1:0] CTRL_RST  = 3'h0;
   localparam logic [15:0]       COUNT_RST = 16'h0000;
   localparam logic [15:0]       TICKS_RST = 16'h0000;

   // clock multipliers applied to (n+1)
   localparam int         PRE_W    = 7;
   localparam logic [6:0] PRE_64   = 7'h40;
   localparam logic [6:0] PRE_16   = 7'h10;
   localparam logic [6:0] PRE_4    = 7'h04;
   localparam logic [6:0] PRE_RST  = 7'h00;

   typedef enum logic [1:0] {
      DIV_64,
      DIV_16,
      DIV_4
   } prescale_e;

endpackage : baud_pkg

// File: design/baud_prescaler.sv
`timescale 1ns/1ns
module baud_prescaler
   import baud_pkg::*;
(
   // clock and reset
   input  wire logic      CLK,
   input  wire logic      NRST,
   // control
   input  wire prescale_e sel,
   input  wire logic      clear,
   // strobe, one cycle in every 64, 16 or 4
   output logic           step
);

   logic [PRE_W-1:0] count_ff;
   logic [PRE_W-1:0] nxt_count;
   logic [PRE_W-1:0] last;

   always_comb begin
      case (sel)
         DIV_64:  last = PRE_64 - 7'h01;
         DIV_16:  last = PRE_16 - 7'h01;
         default: last = PRE_4 - 7'h01;
      endcase
      step      = 1'b0;
      nxt_count = count_ff + 7'h01;
      if (clear) begin
         nxt_count = PRE_RST;
      // >= so a smaller factor chosen mid-count wraps at once
      end else if (count_ff >= last) begin
         nxt_count = PRE_RST;
         step      = 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         count_ff <= PRE_RST;
      end else begin
         count_ff <= nxt_count;
      end
   end

endmodule : baud_prescaler

// File: design/baud_tick_timer.sv
`timescale 1ns/1ns
// How it works
// R1: dedicated 8 or 16 bit rate timer
// R2: 8-bit after reset, 16-bit when select set
// R3: period from divisor pair, free running
// R4: async multiplier from high-speed and width selects
// R5: sync mode ignores the high-speed select
// R6: divisor write clears the timer at once
// R7: async 8-bit normal: clock over 64(n+1)
// R8: async 16-bit normal: clock over 16(n+1)
// R9: sync 8-bit: clock over 4(n+1)
// R10: software checks receive idle before clock change
// R11: software may pick high speed or 16-bit
// R12: other combinations divide by 16 or 4
module baud_tick_timer
   import baud_pkg::*;
#(
   parameter int DIV_W = 16
)
(
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        NRST,
   // avalon-mm slave
   input  wire logic [4:0]  ADDRESS,
   input  wire logic        READ,
   input  wire logic        WRITE,
   input  wire logic [31:0] WRITEDATA,
   input  wire logic [3:0]  BYTEENABLE,
   output logic [31:0]      READDATA,
   output logic             WAITREQUEST,
   // rate outputs
   output logic             BAUD_TICK,
   output logic             SYNC_MODE
);

   // bus state
   logic              wait_ff;
   logic              nxt_wait;
   logic [31:0]       rdata_ff;
   logic [31:0]       nxt_rdata;
   logic              wr_done;

   // software registers
   logic [7:0]        div_lo_ff;
   logic [7:0]        nxt_div_lo;
   logic [7:0]        div_hi_ff;
   logic [7:0]        nxt_div_hi;
   logic [CTRL_W-1:0] ctrl_ff;
   logic [CTRL_W-1:0] nxt_ctrl;
   logic              div_written;

   // timer state
   logic [DIV_W-1:0]  count_ff;
   logic [DIV_W-1:0]  nxt_count;
   logic              tick_ff;
   logic              nxt_tick;
   logic [15:0]       ticks_ff;
   logic [15:0]       nxt_ticks;
   logic              sync_ff;
   logic              nxt_sync;

   // decoded mode
   logic              wide;
   logic              hspeed;
   logic              sync;
   logic [DIV_W-1:0]  reload;
   prescale_e         pre_sel;
   logic              step;

   // bus slave: one wait state, answer on the second edge
   always_comb begin
      nxt_wait  = 1'b1;
      nxt_rdata = rdata_ff;
      wr_done   = WRITE && !wait_ff;
      if ((READ || WRITE) && wait_ff) begin
         nxt_wait = 1'b0;
      end
      if (READ && wait_ff) begin
         if (ADDRESS == DIV_LO_OFS) begin
            nxt_rdata = {24'h000000, div_lo_ff};
         end else if (ADDRESS == DIV_HI_OFS) begin
            nxt_rdata = {24'h000000, div_hi_ff};
         end else if (ADDRESS == CTRL_OFS) begin
            nxt_rdata = {29'h00000000, ctrl_ff};
         end else if (ADDRESS == COUNT_OFS) begin
            nxt_rdata = {16'h0000, 16'(count_ff)};
         end else if (ADDRESS == TICKS_OFS) begin
            nxt_rdata = {16'h0000, ticks_ff};
         end else begin
            // unmapped addresses read as zero
            nxt_rdata = 32'h00000000;
         end
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         wait_ff  <= 1'b1;
         rdata_ff <= 32'h00000000;
      end else begin
         wait_ff  <= nxt_wait;
         rdata_ff <= nxt_rdata;
      end
   end

   // register writes take effect on the edge that sees waitrequest low
   always_comb begin
      nxt_div_lo  = div_lo_ff;
      nxt_div_hi  = div_hi_ff;
      nxt_ctrl    = ctrl_ff;
      div_written = 1'b0;
      if (wr_done && BYTEENABLE[0]) begin
         if (ADDRESS == DIV_LO_OFS) begin
            nxt_div_lo  = WRITEDATA[7:0];
            div_written = 1'b1; // R6
         end else if (ADDRESS == DIV_HI_OFS) begin
            nxt_div_hi  = WRITEDATA[7:0];
            div_written = 1'b1; // R6
         end else if (ADDRESS == CTRL_OFS) begin
            nxt_ctrl = WRITEDATA[CTRL_W-1:0];
         end else begin
            // other addresses ignore writes
            nxt_ctrl = ctrl_ff;
         end
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         div_lo_ff <= DIV_RST;
         div_hi_ff <= DIV_RST;
         ctrl_ff   <= CTRL_RST; // R2
      end else begin
         div_lo_ff <= nxt_div_lo;
         div_hi_ff <= nxt_div_hi;
         ctrl_ff   <= nxt_ctrl;
      end
   end

   // mode decode
   always_comb begin
      wide   = ctrl_ff[CTRL_WIDE_BIT];
      hspeed = ctrl_ff[CTRL_HSPEED_BIT];
      sync   = ctrl_ff[CTRL_SYNC_BIT];
      // 8-bit mode counts the low byte only
      if (wide) begin
         reload = DIV_W'({div_hi_ff, div_lo_ff}); // R1 R2 R3
      end else begin
         reload = DIV_W'(div_lo_ff); // R1 R2
      end
      if (sync) begin
         pre_sel = DIV_4; // R5 R9 R12
      end else if (!wide && !hspeed) begin
         pre_sel = DIV_64; // R4 R7
      end else if (!wide && hspeed) begin
         pre_sel = DIV_16; // R4 R12
      end else if (wide && !hspeed) begin
         pre_sel = DIV_16; // R4 R8
      end else begin
         pre_sel = DIV_4; // R4 R12
      end
   end

   // the divisor write also restarts the multiplier stage
   baud_prescaler u_prescaler (
      .CLK   (CLK),
      .NRST  (NRST),
      .sel   (pre_sel),
      .clear (div_written), // R6
      .step  (step)
   );

   // down-count timer, reloaded on expiry, never stopped
   always_comb begin
      nxt_count = count_ff;
      nxt_tick  = 1'b0;
      nxt_ticks = ticks_ff;
      nxt_sync  = sync;
      if (div_written) begin
         // load the new value so the new rate starts this cycle
         nxt_count = DIV_W'(wide ? {nxt_div_hi, nxt_div_lo} : {8'h00, nxt_div_lo}); // R6
      end else if (step) begin
         if (count_ff == '0) begin
            nxt_count = reload; // R3
            nxt_tick  = 1'b1;
            nxt_ticks = ticks_ff + 16'h0001;
         end else begin
            nxt_count = count_ff - DIV_W'(1);
         end
      end else if (count_ff > reload) begin
         // width change left a count above the period
         nxt_count = reload;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         count_ff <= DIV_W'(COUNT_RST);
         tick_ff  <= 1'b0;
         ticks_ff <= TICKS_RST;
         sync_ff  <= 1'b0;
      end else begin
         count_ff <= nxt_count;
         tick_ff  <= nxt_tick;
         ticks_ff <= nxt_ticks;
         sync_ff  <= nxt_sync;
      end
   end

   assign READDATA    = rdata_ff;
   assign WAITREQUEST = wait_ff;
   assign BAUD_TICK   = tick_ff;
   assign SYNC_MODE   = sync_ff;

endmodule : baud_tick_timer

// File: tb/baud_tick_timer_monitor.sv
`timescale 1ns/1ns
module baud_monitor
   import baud_pkg::*;
#(
   parameter int DIV_W = 16
)
(
   // clock and reset
   input wire logic        CLK,
   input wire logic        NRST,
   // bus
   input wire logic [4:0]  ADDRESS,
   input wire logic        READ,
   input wire logic        WRITE,
   input wire logic [31:0] WRITEDATA,
   input wire logic [3:0]  BYTEENABLE,
   input wire logic [31:0] READDATA,
   input wire logic        WAITREQUEST,
   // rate
   input wire logic        BAUD_TICK,
   input wire logic        SYNC_MODE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);
   sequence wr_done;
      WRITE && !WAITREQUEST && BYTEENABLE[0];
   endsequence
   sequence quiet3;
      !BAUD_TICK [*3];
   endsequence
   wait_answer_a: assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
      else $error("request not answered");
   wait_single_a: assert property (!WAITREQUEST |=> WAITREQUEST) else $error("waitrequest low too long");
   tick_gap_a: assert property (BAUD_TICK |=> quiet3) else $error("ticks too close");
   // no tick can land one cycle after the write either, as the write forces the next tick low; the check still skips that cycle
   div_restart_a: assert property (wr_done ##0 (ADDRESS == DIV_LO_OFS || ADDRESS == DIV_HI_OFS)
      |=> ##1 quiet3) else $error("tick too soon after divisor write");
   reset_quiet_a: assert property ($rose(NRST) |-> !BAUD_TICK [*8]) else $error("early tick");
   sync_copy_a: assert property (wr_done ##0 ADDRESS == CTRL_OFS
      |-> ##2 SYNC_MODE == $past(WRITEDATA[CTRL_SYNC_BIT], 2)) else $error("sync mode not copied");
   data_hold_a: assert property (!(READ && WAITREQUEST) |=> $stable(READDATA)) else $error("readdata moved");
   unmapped_zero_a: assert property (READ && WAITREQUEST && ADDRESS > TICKS_OFS |=> READDATA == 32'h0)
      else $error("unmapped read not zero");
   ctrl_upper_a: assert property (READ && WAITREQUEST && ADDRESS == CTRL_OFS |=> READDATA[31:3] == 29'h0)
      else $error("control upper bits set");
endmodule : baud_monitor

bind baud_tick_timer baud_monitor #(.DIV_W(DIV_W)) u_baud_monitor (.CLK(CLK), .NRST(NRST),
   .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE),
   .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .BAUD_TICK(BAUD_TICK), .SYNC_MODE(SYNC_MODE));

// File: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
   import baud_pkg::*;
   logic        CLK = 1'b0, NRST = 1'b0, READ = 1'b0, WRITE = 1'b0;
   logic [4:0]  ADDRESS = 5'h00;
   logic [31:0] WRITEDATA = 32'h0, READDATA, q;
   logic [3:0]  BYTEENABLE = 4'hf;
   logic        WAITREQUEST, BAUD_TICK, SYNC_MODE;
   logic [7:0]  hi, lo;
   logic [15:0] ticks_seen = 16'h0000;
   int          num_errors = 0, n_compared = 0, cyc = 0;

   baud_tick_timer u_baud_tick_timer (.CLK(CLK), .NRST(NRST), .ADDRESS(ADDRESS), .READ(READ),
      .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
      .WAITREQUEST(WAITREQUEST), .BAUD_TICK(BAUD_TICK), .SYNC_MODE(SYNC_MODE));

   // the system clock never changes rate, so no reception can be upset
   always #25 CLK = ~CLK;

   // independent tally of rate ticks, read back through the tick counter register
   always @(posedge CLK) begin
      if (BAUD_TICK === 1'b1) begin
         ticks_seen <= ticks_seen + 16'h0001;
      end
   end

   task automatic stop_test();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test

   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         num_errors++;
         stop_test();
      end
   end

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %0t reg %h exp %h", $time, got, exp);
      end
   endtask : chk_reg

   task automatic chk_cnt(input int got, input int exp);
      n_compared++;
      if (got != exp) begin
         num_errors++;
         $display("CHECK FAILED %0t gap %0d exp %0d", $time, got, exp);
      end
   endtask : chk_cnt

   // one access; the extra edge keeps back-to-back calls from reassigning in one step
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
      ADDRESS <= a;
      WRITE <= w;
      READ <= !w;
      WRITEDATA <= d;
      BYTEENABLE <= be;
      do @(posedge CLK); while (WAITREQUEST !== 1'b0);
      q = READDATA;
      WRITE <= 1'b0;
      READ <= 1'b0;
      @(posedge CLK);
   endtask : bus

   function automatic int exp_p(logic [2:0] c, logic [7:0] h, logic [7:0] l);
      int m;
      m = (c[2] || (c[0] && c[1])) ? 4 : (c[0] || c[1]) ? 16 : 64;
      return m * (int'(c[0] ? {h, l} : {8'h00, l}) + 1);
   endfunction : exp_p

   task automatic measure(input int per, input bit fresh);
      int c;
      @(posedge CLK);
      c = 2;
      while (BAUD_TICK !== 1'b1) begin
         @(posedge CLK);
         c++;
      end
      if (fresh) chk_cnt(c, per + 1);
      @(posedge CLK);
      c = 1;
      while (BAUD_TICK !== 1'b1) begin
         @(posedge CLK);
         c++;
      end
      chk_cnt(c, per);
   endtask : measure

   initial begin
      void'($urandom(43));
      repeat (4) @(posedge CLK);
      NRST <= 1'b1;
      bus(1'b0, CTRL_OFS, 32'h0, 4'hf);
      chk_reg(q, 32'h0);
      bus(1'b0, 5'h14, 32'h0, 4'hf);
      chk_reg(q, 32'h0);
      for (int c = 0; c < 8; c++) begin
         hi = 8'($urandom_range(1, 0));
         lo = (c == 5) ? 8'h00 : 8'($urandom_range(15, 0));
         bus(1'b1, CTRL_OFS, 32'(c), 4'hf);
         bus(1'b0, CTRL_OFS, 32'h0, 4'hf);
         chk_reg(q, 32'(c));
         chk_reg({31'h0, SYNC_MODE}, {31'h0, c[2]});
         bus(1'b1, DIV_HI_OFS, {24'h0, hi}, 4'hf);
         bus(1'b1, DIV_LO_OFS, {24'h0, lo}, 4'hf);
         measure(exp_p(3'(c), hi, lo), 1'b1);
         // read right after a tick: the next one cannot land before the read is taken
         bus(1'b0, TICKS_OFS, 32'h0, 4'hf);
         chk_reg(q, {16'h0000, ticks_seen});
         bus(1'b0, DIV_LO_OFS, 32'h0, 4'hf);
         chk_reg(q, {24'h000000, lo});
         bus(1'b0, DIV_HI_OFS, 32'h0, 4'hf);
         chk_reg(q, {24'h000000, hi});
      end
      bus(1'b1, CTRL_OFS, 32'h0, 4'h0);
      bus(1'b0, CTRL_OFS, 32'h0, 4'hf);
      chk_reg(q, 32'h7);
      // second reset in mid-run: back to 8-bit async, divisor 0
      NRST <= 1'b0;
      repeat (2) @(posedge CLK);
      NRST <= 1'b1;
      bus(1'b0, CTRL_OFS, 32'h0, 4'hf);
      chk_reg(q, 32'h0);
      chk_reg({31'h0, SYNC_MODE}, 32'h0);
      measure(exp_p(3'h0, 8'h00, 8'h00), 1'b0);
      stop_test();
   end
endmodule : testbench
